// ===== verilog/misc_regs_pkg.sv
// constants shared by the host system register bank
// assumes a 16-bit host bus with byte address bits 7:1 and a 100 MHz system clock
package misc_regs_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_TIMER_COUNT = 8'h90;
   localparam logic [7:0] OFF_WORD_ORDER = 8'h98;
   localparam logic [7:0] OFF_CYCLE_COUNT = 8'h9c;
   localparam logic [7:0] OFF_DROPPED = 8'ha0;
   localparam logic [7:0] OFF_LINK_CMD = 8'ha4;
   localparam logic [7:0] OFF_LINK_VALUE = 8'ha8;

   // reset values
   localparam logic [15:0] RST_TIMER_COUNT = 16'hffff;
   localparam logic [31:0] RST_WORD_ORDER = 32'h00000000;
   localparam logic [31:0] RST_CYCLE_COUNT = 32'h00000000;
   localparam logic [31:0] RST_DROPPED = 32'h00000000;
   localparam logic [7:0] RST_LINK_INDEX = 8'h00;
   localparam logic [31:0] RST_LINK_VALUE = 32'h00000000;

   // word order pattern that inverts the half mapping
   localparam logic [31:0] SWAP_PATTERN = 32'hffffffff;

   // command register fields
   localparam int CMD_BUSY_BIT = 31;
   localparam int CMD_DIR_BIT = 30;
   localparam int CMD_INDEX_W = 8;
   // same fields seen in the upper host half-word
   localparam int CMD_HI_BUSY_BIT = CMD_BUSY_BIT - 16;
   localparam int CMD_HI_DIR_BIT = CMD_DIR_BIT - 16;

   // dropped frame counter midpoint bit
   localparam int DROP_HALF_BIT = 31;

   // timing
   localparam int SYS_CLK_MHZ = 100;
   localparam int CYCLE_CLK_MHZ = 25;
   localparam logic [1:0] CYCLE_DIV_LAST = 2'(SYS_CLK_MHZ / CYCLE_CLK_MHZ - 1);

   // indirect access handshake states, gray coded except the two-bit step from LINK_RELEASE back to LINK_IDLE
   typedef enum logic [1:0] {
      LINK_IDLE = 2'b00,
      LINK_REQ = 2'b01,
      LINK_RELEASE = 2'b11
   } link_state_e;

endpackage

// ===== verilog/host_misc_system_registers.sv
// host visible system registers: timer count view, word order control,
// 25 MHz cycle counter, dropped frame tally and indirect link layer access.
// assumes an asynchronous 16-bit host bus whose address and data are stable
// around the strobes, and a link layer register port using a four-phase
// req/ack handshake with read data held stable while ack is high.
//
// Summary of operation
// - timer count reads low half, resets ffff
// - transmit low half-word goes out first
// - first received half-word lands in low half
// - normal mapping: address bit one selects upper
// - all-ones word order inverts half mapping
// - 32-bit counter from zero at 25 MHz
// - counter wraps to zero and keeps going
// - first half read snapshots whole count
// - counter clears promptly after reset
// - counter never gated by power state
// - dropped counter increments per dropped frame
// - first half read returns then clears tally
// - event when tally crosses its midpoint
// - writing busy launches indirect access
// - busy stays set until access completes
// - read data present before busy clears
// - bit 30 picks read or write
// - bits 7:0 name the target register
// - data register carries write or read value
// - timer runs while enabled, halts otherwise
`timescale 1ns/10ps

module host_misc_system_registers (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // host bus
   input wire logic host_cs_n,
   input wire logic host_rd_n,
   input wire logic host_wr_n,
   input wire logic [7:1] host_addr,
   input wire logic [15:0] host_wdata,
   output logic [15:0] host_rdata,
   // general purpose timer control
   input wire logic timer_enable,
   input wire logic [15:0] timer_preload_value,
   // receiver
   input wire logic rx_frame_dropped,
   output logic drop_half_event,
   // link layer register port
   output logic link_req,
   output logic access_direction,
   output logic [misc_regs_pkg::CMD_INDEX_W-1:0] link_index,
   output logic [31:0] link_wdata,
   input wire logic link_ack,
   input wire logic [31:0] link_rdata
);
   import misc_regs_pkg::*;

   localparam int SYNC_W = 27;

   function automatic logic reg_hit(input logic [6:0] a, input logic [7:0] off);
      reg_hit = (a[6:1] == off[7:2]);
   endfunction

   // two-stage synchroniser for host pins and the link ack
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic rd_prev_reg;
   logic wr_prev_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= {3'h7, 24'h000000};
         sync2_reg <= {3'h7, 24'h000000};
      end else begin
         sync1_reg <= {host_cs_n, host_rd_n, host_wr_n, host_addr, host_wdata, link_ack};
         sync2_reg <= sync1_reg;
      end
   end

   wire cs_s = ~sync2_reg[26];
   wire rd_s = cs_s & ~sync2_reg[25];
   wire wr_s = cs_s & ~sync2_reg[24];
   wire [6:0] addr_s = sync2_reg[23:17];
   wire [15:0] wdata_s = sync2_reg[16:1];
   wire ack_s = sync2_reg[0];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_prev_reg <= 1'b0;
         wr_prev_reg <= 1'b0;
      end else begin
         rd_prev_reg <= rd_s;
         wr_prev_reg <= wr_s;
      end
   end

   wire rd_go = rd_s & ~rd_prev_reg;
   wire wr_go = wr_s & ~wr_prev_reg;

   // register storage
   logic [15:0] timer_count_reg;
   logic timer_en_prev_reg;
   logic [31:0] swap_reg;
   logic [1:0] prescale_reg;
   logic [31:0] cycle_count_reg;
   logic [31:0] cycle_snap_reg;
   logic cycle_held_reg;
   logic [31:0] drop_count_reg;
   logic [31:0] drop_snap_reg;
   logic drop_held_reg;
   logic busy_reg;
   logic dir_reg;
   logic [CMD_INDEX_W-1:0] index_reg;
   logic [31:0] value_reg;
   link_state_e state_reg;

   // address decode and half selection
   wire swap_on = (swap_reg == SWAP_PATTERN);
   wire upper_sel = addr_s[0] ^ swap_on;
   wire hit_timer = reg_hit(addr_s, OFF_TIMER_COUNT);
   wire hit_swap = reg_hit(addr_s, OFF_WORD_ORDER);
   wire hit_cycle = reg_hit(addr_s, OFF_CYCLE_COUNT);
   wire hit_drop = reg_hit(addr_s, OFF_DROPPED);
   wire hit_cmd = reg_hit(addr_s, OFF_LINK_CMD);
   wire hit_value = reg_hit(addr_s, OFF_LINK_VALUE);
   wire wr_lo = wr_go & ~upper_sel;
   wire wr_hi = wr_go & upper_sel;

   // transmit and receive word halves: the low half travels first on the link,
   // so the host view of halves is the only thing word order changes
   wire [31:0] cycle_word = cycle_held_reg ? cycle_snap_reg : cycle_count_reg;
   wire [31:0] drop_word = drop_held_reg ? drop_snap_reg : drop_count_reg;
   wire [31:0] cmd_word = {busy_reg, dir_reg, 22'h000000, index_reg};
   wire [31:0] read_word = hit_timer ? {16'h0000, timer_count_reg} :
      hit_swap ? swap_reg :
      hit_cycle ? cycle_word :
      hit_drop ? drop_word :
      hit_cmd ? cmd_word :
      hit_value ? value_reg :
      32'h00000000;
   wire [15:0] read_half = upper_sel ? read_word[31:16] : read_word[15:0];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         host_rdata <= 16'h0000;
      end else if (rd_go) begin
         host_rdata <= read_half;
      end
   end

   // general purpose timer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timer_count_reg <= RST_TIMER_COUNT;
         timer_en_prev_reg <= 1'b0;
      end else begin
         timer_en_prev_reg <= timer_enable;
         if (timer_enable && !timer_en_prev_reg) begin
            timer_count_reg <= timer_preload_value;
         end else if (timer_enable) begin
            timer_count_reg <= timer_count_reg - 16'h0001;
         end
      end
   end

   // word order control
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         swap_reg <= RST_WORD_ORDER;
      end else if (hit_swap) begin
         if (wr_lo) begin
            swap_reg[15:0] <= wdata_s;
         end
         if (wr_hi) begin
            swap_reg[31:16] <= wdata_s;
         end
      end
   end

   // 25 MHz cycle counter: reset clears it at once, no power state input gates it
   wire cycle_tick = (prescale_reg == CYCLE_DIV_LAST);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prescale_reg <= 2'h0;
         cycle_count_reg <= RST_CYCLE_COUNT;
      end else begin
         prescale_reg <= cycle_tick ? 2'h0 : prescale_reg + 2'h1;
         if (cycle_tick) begin
            cycle_count_reg <= cycle_count_reg + 32'h00000001;
         end
      end
   end

   // first half read latches the full count, second half read releases it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cycle_snap_reg <= RST_CYCLE_COUNT;
         cycle_held_reg <= 1'b0;
      end else if (rd_go && hit_cycle) begin
         if (!cycle_held_reg) begin
            cycle_snap_reg <= cycle_count_reg;
         end
         cycle_held_reg <= ~cycle_held_reg;
      end
   end

   // dropped frame tally; a drop in the clearing cycle is kept
   wire drop_clear = rd_go & hit_drop & ~drop_held_reg;
   wire [31:0] drop_base = drop_clear ? RST_DROPPED : drop_count_reg;
   wire [31:0] drop_next = rx_frame_dropped ? drop_base + 32'h00000001 : drop_base;
   wire drop_cross = ~drop_count_reg[DROP_HALF_BIT] & drop_next[DROP_HALF_BIT] & ~drop_clear;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         drop_count_reg <= RST_DROPPED;
         drop_snap_reg <= RST_DROPPED;
         drop_held_reg <= 1'b0;
         drop_half_event <= 1'b0;
      end else begin
         drop_count_reg <= drop_next;
         drop_half_event <= drop_cross;
         if (rd_go && hit_drop) begin
            if (!drop_held_reg) begin
               drop_snap_reg <= drop_count_reg;
            end
            drop_held_reg <= ~drop_held_reg;
         end
      end
   end

   // indirect link layer access
   wire cmd_start = wr_hi & hit_cmd & ~busy_reg & wdata_s[CMD_HI_BUSY_BIT];
   wire host_may_write = ~busy_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dir_reg <= 1'b0;
         index_reg <= RST_LINK_INDEX;
      end else if (hit_cmd && host_may_write) begin
         if (wr_lo) begin
            index_reg <= wdata_s[CMD_INDEX_W-1:0];
         end
         if (wr_hi) begin
            dir_reg <= wdata_s[CMD_HI_DIR_BIT];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         value_reg <= RST_LINK_VALUE;
      end else if (state_reg == LINK_REQ && ack_s && access_direction) begin
         value_reg <= link_rdata;
      end else if (hit_value && host_may_write) begin
         if (wr_lo) begin
            value_reg[15:0] <= wdata_s;
         end
         if (wr_hi) begin
            value_reg[31:16] <= wdata_s;
         end
      end
   end

   // four-phase handshake: req until ack seen, then wait for ack to drop
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= LINK_IDLE;
         busy_reg <= 1'b0;
         link_req <= 1'b0;
         access_direction <= 1'b0;
         link_index <= RST_LINK_INDEX;
         link_wdata <= RST_LINK_VALUE;
      end else begin
         case (state_reg)
            LINK_IDLE: begin
               if (cmd_start) begin
                  busy_reg <= 1'b1;
                  link_req <= 1'b1;
                  access_direction <= wdata_s[CMD_HI_DIR_BIT];
                  link_index <= index_reg;
                  link_wdata <= value_reg;
                  state_reg <= LINK_REQ;
               end
            end
            LINK_REQ: begin
               if (ack_s) begin
                  link_req <= 1'b0;
                  state_reg <= LINK_RELEASE;
               end
            end
            LINK_RELEASE: begin
               if (!ack_s) begin
                  busy_reg <= 1'b0;
                  state_reg <= LINK_IDLE;
               end
            end
            default: begin
               busy_reg <= 1'b0;
               link_req <= 1'b0;
               state_reg <= LINK_IDLE;
            end
         endcase
      end
   end

endmodule

// ===== dv/host_misc_system_registers_chk.sv
// port checker for the host system register bank
// assumes it is bound to the bank's top module on the system clock
`timescale 1ns/10ps
module host_misc_system_registers_chk (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // host bus
   input wire logic host_cs_n,
   input wire logic host_rd_n,
   input wire logic host_wr_n,
   input wire logic [15:0] host_rdata,
   // receiver
   input wire logic rx_frame_dropped,
   input wire logic drop_half_event,
   // link port
   input wire logic link_req,
   input wire logic access_direction,
   input wire logic [misc_regs_pkg::CMD_INDEX_W-1:0] link_index,
   input wire logic [31:0] link_wdata,
   input wire logic link_ack
);
   import misc_regs_pkg::*;
   // cycles since each strobe was last seen low at the pins
   logic [3:0] rd_age_reg, wr_age_reg;
   wire logic [3:0] rd_age_next = (!host_cs_n && !host_rd_n) ? 4'h0 : rd_age_reg + 4'(rd_age_reg != 4'hf);
   wire logic [3:0] wr_age_next = (!host_cs_n && !host_wr_n) ? 4'h0 : wr_age_reg + 4'(wr_age_reg != 4'hf);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_age_reg <= 4'hf;
         wr_age_reg <= 4'hf;
      end else begin
         rd_age_reg <= rd_age_next;
         wr_age_reg <= wr_age_next;
      end
   end
   // checks stay off for one edge after each reset release, so that
   // sampled-value functions other than the two-cycle $past never look back into the reset period
   logic rst_hold_reg;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rst_hold_reg <= 1'b1;
      end else begin
         rst_hold_reg <= 1'b0;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst || rst_hold_reg);
   sequence ack_seen;
      link_req && link_ack;
   endsequence
   chk_req_drops_ack: assert property (ack_seen |-> ##[1:4] !link_req)
      else $error("link request held after ack");
   chk_req_holds: assert property (link_req && !link_ack |=> link_req)
      else $error("link request dropped before ack");
   chk_fields_held: assert property (link_req ##1 link_req |-> $stable({access_direction, link_index, link_wdata}))
      else $error("link fields moved during request");
   chk_no_early_req: assert property ($rose(link_req) |-> !link_ack && !$past(link_ack))
      else $error("link request before ack fell");
   chk_req_from_write: assert property ($rose(link_req) |-> wr_age_reg < 4'h4)
      else $error("link request without host write");
   chk_rdata_on_read: assert property (!$stable(host_rdata) |-> rd_age_reg < 4'h4)
      else $error("read data moved without a read");
   chk_half_from_drop: assert property (drop_half_event |-> $past(rx_frame_dropped) || $past(rx_frame_dropped, 2))
      else $error("half event without a dropped frame");
   chk_idle_after_ack: assert property (!link_req && link_ack |=> !link_req)
      else $error("link request while ack still high");
endmodule
bind host_misc_system_registers host_misc_system_registers_chk u_chk (.sys_clk, .rst, .host_cs_n, .host_rd_n,
   .host_wr_n, .host_rdata, .rx_frame_dropped, .drop_half_event, .link_req, .access_direction, .link_index,
   .link_wdata, .link_ack);

// ===== dv/link_csr_model.sv
// link layer register file answering the four-phase indirect port
// assumes the bank's clock; ack_wait sets how slowly it answers
`timescale 1ns/10ps
module link_csr_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // request side
   input wire logic link_req,
   input wire logic access_direction,
   input wire logic [7:0] link_index,
   input wire logic [31:0] link_wdata,
   input wire logic [3:0] ack_wait,
   // answer side
   output logic link_ack,
   output logic [31:0] link_rdata
);
   logic [31:0] mem [256];
   logic [3:0] wait_reg;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         link_ack <= 1'b0;
         link_rdata <= 32'h5a5a5a5a;
         wait_reg <= 4'h0;
      end else if (!link_req) begin
         // released data no longer holds the answer
         if (link_ack) link_rdata <= ~link_rdata;
         link_ack <= 1'b0;
         wait_reg <= 4'h0;
      end else if (!link_ack) begin
         wait_reg <= wait_reg + 4'h1;
         if (wait_reg == ack_wait) begin
            link_ack <= 1'b1;
            if (access_direction) link_rdata <= mem[link_index];
            else mem[link_index] <= link_wdata;
         end
      end
   end
endmodule

// ===== dv/host_misc_system_registers_tb.sv
// self-checking bench for the host system register bank
// assumes the link register model on the far side of the indirect port
`timescale 1ns/10ps
module host_misc_system_registers_tb;
   import misc_regs_pkg::*;
   logic sys_clk, rst = 1'b1, host_cs_n = 1'b1, host_rd_n = 1'b1, host_wr_n = 1'b1;
   logic [7:1] host_addr = 7'h0;
   logic [15:0] host_wdata = 16'h0, timer_preload_value = 16'h0, host_rdata, q;
   logic timer_enable = 1'b0, rx_frame_dropped = 1'b0, drop_half_event, link_req, access_direction, link_ack;
   logic [7:0] link_index;
   logic [31:0] link_wdata, link_rdata, v, w;
   logic [3:0] ack_wait = 4'hf;
   int err_count = 0;
   int compares = 0;
   host_misc_system_registers u_dut (.sys_clk, .rst, .host_cs_n, .host_rd_n, .host_wr_n, .host_addr, .host_wdata,
      .host_rdata, .timer_enable, .timer_preload_value, .rx_frame_dropped, .drop_half_event, .link_req,
      .access_direction, .link_index, .link_wdata, .link_ack, .link_rdata);
   link_csr_model u_model (.sys_clk, .rst, .link_req, .access_direction, .link_index, .link_wdata, .ack_wait,
      .link_ack, .link_rdata);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // one host access: strobe held past the take, read data kept in q
   task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      host_cs_n <= 1'b0;
      host_rd_n <= wr;
      host_wr_n <= !wr;
      host_addr <= a[7:1];
      host_wdata <= d;
      repeat (5) @(posedge sys_clk);
      q = host_rdata;
      host_cs_n <= 1'b1;
      host_rd_n <= 1'b1;
      host_wr_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [15:0] e);
      acc(1'b0, a, 16'h0000);
      chk($sformatf("addr %h", a), {16'h0, q}, {16'h0, e});
   endtask
   task automatic wait_idle();
      repeat (20) begin
         acc(1'b0, 8'ha6, 16'h0000);
         if (q[15] === 1'b0) return;
      end
      chk("busy", {31'h0, q[15]}, 32'h0);
   endtask
   task automatic t_reset();
      logic [7:0] a [9] = '{8'h90, 8'h92, 8'h94, 8'h98, 8'ha0, 8'ha2, 8'ha4, 8'ha6, 8'haa};
      foreach (a[i]) rc(a[i], (i == 0) ? 16'hffff : 16'h0000);
      $display("reset values done");
   endtask
   task automatic t_timer();
      timer_preload_value <= 16'h1234;
      timer_enable <= 1'b1;
      repeat (20) @(posedge sys_clk);
      timer_enable <= 1'b0;
      // loaded on the first enabled edge, then 19 decrements, then held
      rc(8'h90, 16'h1221);
      acc(1'b1, 8'h90, 16'h0000);
      rc(8'h90, 16'h1221);
      $display("timer done");
   endtask
   task automatic t_cycle();
      acc(1'b0, 8'h9c, 16'h0000);
      v[15:0] = q;
      acc(1'b0, 8'h9e, 16'h0000);
      v[31:16] = q;
      repeat (400) @(posedge sys_clk);
      acc(1'b0, 8'h9c, 16'h0000);
      w[15:0] = q;
      acc(1'b0, 8'h9e, 16'h0000);
      w[31:16] = q;
      chk("count step", w - v, 32'h69);
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      rc(8'h9c, 16'h0000);
      rc(8'h9e, 16'h0000);
      $display("cycle counter done");
   endtask
   task automatic t_drop();
      rx_frame_dropped <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rx_frame_dropped <= 1'b0;
      rc(8'ha0, 16'h0005);
      chk("half event", {31'h0, drop_half_event}, 32'h0);
      rc(8'ha2, 16'h0000);
      rc(8'ha0, 16'h0000);
      rc(8'ha2, 16'h0000);
      $display("dropped tally done");
   endtask
   task automatic t_swap();
      acc(1'b1, 8'h98, 16'hffff);
      acc(1'b1, 8'h9a, 16'hffff);
      acc(1'b1, 8'ha8, 16'h1111);
      acc(1'b1, 8'haa, 16'h2222);
      rc(8'ha8, 16'h1111);
      rc(8'h90, 16'h0000);
      acc(1'b1, 8'h98, 16'h0000);
      rc(8'ha8, 16'h2222);
      rc(8'h98, 16'hffff);
      $display("word order done");
   endtask
   task automatic t_link();
      acc(1'b1, 8'ha8, 16'h0123);
      acc(1'b1, 8'haa, 16'hcafe);
      acc(1'b1, 8'ha4, 16'h005a);
      acc(1'b1, 8'ha6, 16'h8000);
      rc(8'ha6, 16'h8000);
      wait_idle();
      chk("far word", u_model.mem[8'h5a], 32'hcafe0123);
      acc(1'b1, 8'ha8, 16'h0000);
      acc(1'b1, 8'haa, 16'h0000);
      ack_wait <= 4'h0;
      acc(1'b1, 8'ha6, 16'hc000);
      wait_idle();
      rc(8'ha6, 16'h4000);
      rc(8'ha4, 16'h005a);
      rc(8'ha8, 16'h0123);
      rc(8'haa, 16'hcafe);
      $display("indirect access done");
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_count++;
      results();
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_timer();
      t_cycle();
      t_drop();
      t_swap();
      t_link();
      results();
   end
endmodule
